//--- logic/clkgen_consts.svh
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH

// Register byte offsets
`define CKG_CTRL_OFS       8'h00
`define CKG_STATUS_OFS     8'h04

// Control word fields (factors stored minus one)
`define CKG_MODE_LSB       0
`define CKG_HALF_BIT       2
`define CKG_PDIV_LSB       4
`define CKG_NDIV_LSB       8
`define CKG_KDIV_LSB       16

// Status word fields
`define CKG_ST_MODE_LSB    0
`define CKG_ST_HALF_BIT    2
`define CKG_ST_BUSY_BIT    3
`define CKG_ST_LOCK_BIT    4

// Reset values
`define CKG_MODE_RST       2'h0
`define CKG_HALF_RST       1'h0
`define CKG_PDIV_RST       4'h0
`define CKG_NDIV_RST       7'h0
`define CKG_KDIV_RST       4'h0

// Free-running oscillator half period in clk_i cycles
`define CKG_VCO_BASE_HALF  16'h0005
// Cycles after reset release before the strap is caught
`define CKG_STRAP_WAIT     2'h2

`endif

//--- logic/clkgen_pkg.sv
package clkgen_pkg;

  typedef enum logic [1:0]
  {
    MODE_DIRECT    = 2'b00,
    MODE_PRESCALER = 2'b01,
    MODE_PLL       = 2'b10,
    MODE_BASE      = 2'b11
  } clk_mode_t;

  typedef enum logic [1:0]
  {
    ST_IDLE     = 2'b00,
    ST_WAIT_LOW = 2'b01,
    ST_SETTLE   = 2'b10
  } switch_state_t;

endpackage : clkgen_pkg

//--- logic/clock_divider.sv
// Divides a sampled clock level by an integer factor.
module clock_divider
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       restart_i,
  input  wire logic       src_i,
  input  wire logic [6:0] factor_m1_i,
  output logic            clk_o
);

  logic       src_q;
  logic [6:0] cnt;
  logic       div_q;

  wire logic       rise     = src_i & ~src_q;
  wire logic [6:0] next_cnt = (cnt >= factor_m1_i) ? 7'h00 : cnt + 7'h01;
  // High for the first half; odd factors get the longer half high
  wire logic [7:0] half     = ({1'b0, factor_m1_i} + 8'h02) >> 1;

  // Count source rising edges; restart parks div_q low (factor one still passes the source to clk_o)
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      src_q <= 1'b0;
      cnt   <= 7'h00;
      div_q <= 1'b0;
    end
    else
    begin
      src_q <= src_i;
      if (restart_i)
      begin
        cnt   <= factor_m1_i;
        div_q <= 1'b0;
      end
      else if (rise)
      begin
        cnt   <= next_cnt;
        div_q <= ({1'b0, next_cnt} < half);
      end
    end
  end

  // Factor one passes the source through untouched
  assign clk_o = (factor_m1_i == 7'h00) ? src_i : div_q;

endmodule : clock_divider

//--- logic/clock_generation_unit.sv
// The register addresses and the APB slave port were chosen for this implementation.
`include "clkgen_consts.svh"

module clock_generation_unit
  import clkgen_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        oscillator_clock_i,
  input  wire logic [1:0]  mode_strap_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             cpu_clock_o,
  output logic             system_clock_o,
  output logic             controlled_oscillator_clock_o
);

  // Pin synchronisers
  logic       osc_s1;
  logic       osc_s2;
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  logic [1:0] strap_cnt;

  // Pending (software view) and active configuration
  clk_mode_t  pend_mode;
  logic       pend_half;
  logic [3:0] pend_pdiv;
  logic [6:0] pend_ndiv;
  logic [3:0] pend_kdiv;
  clk_mode_t  act_mode;
  logic       act_half;
  logic [3:0] act_pdiv;
  logic [6:0] act_ndiv;
  logic [3:0] act_kdiv;

  switch_state_t state;
  switch_state_t next_state;

  // Reference measurement and oscillator model
  logic        pref_q;
  logic [15:0] per_cnt;
  logic [15:0] ref_period;
  logic        meas_valid;
  logic [16:0] acc;
  logic        vco_q;

  logic        pdiv_clk;
  logic        cpu_pre;
  logic        sys_pre;

  // Two flops before any logic sees the pins
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      osc_s1   <= 1'b0;
      osc_s2   <= 1'b0;
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
    end
    else
    begin
      osc_s1   <= oscillator_clock_i;
      osc_s2   <= osc_s1;
      strap_s1 <= mode_strap_i;
      strap_s2 <= strap_s1;
    end
  end

  // Predivider on the oscillator clock
  clock_divider u_pdiv
  (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .restart_i   (1'b0),
    .src_i       (osc_s2),
    .factor_m1_i ({3'h0, act_pdiv}),
    .clk_o       (pdiv_clk)
  );

  // Reference period in clk_i cycles, rise to rise
  wire logic pref_rise = pdiv_clk & ~pref_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pref_q     <= 1'b0;
      per_cnt    <= 16'h0000;
      ref_period <= 16'h0000;
      meas_valid <= 1'b0;
    end
    else
    begin
      pref_q <= pdiv_clk;
      if (pref_rise)
      begin
        per_cnt    <= 16'h0001;
        ref_period <= per_cnt;
        meas_valid <= (per_cnt != 16'h0000);
      end
      else if (per_cnt != 16'hFFFF)
      begin
        per_cnt <= per_cnt + 16'h0001; // Saturates on a dead reference
      end
    end
  end

  // Oscillator as a phase accumulator: toggles 2N times per reference
  // period in PLL mode; free-running at a fixed half period otherwise
  wire logic        vco_base = (act_mode != MODE_PLL);
  wire logic [16:0] vco_step = vco_base ? 17'h00001
                                        : {9'h000, act_ndiv, 1'b0} + 17'h00002;
  wire logic [16:0] vco_mod  = vco_base ? {1'b0, `CKG_VCO_BASE_HALF}
                                        : {1'b0, ref_period};
  wire logic [16:0] acc_sum  = acc + vco_step;
  wire logic        vco_wrap = (acc_sum >= vco_mod) && (vco_mod != 17'h00000);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acc   <= 17'h00000;
      vco_q <= 1'b0;
    end
    else if (vco_wrap)
    begin
      acc   <= acc_sum - vco_mod;
      vco_q <= ~vco_q;
    end
    else
    begin
      acc <= acc_sum;
    end
  end

  // Source selection per mode
  function automatic logic pick_src(clk_mode_t m, logic osc, logic pdv, logic vco);
    case (m)
      MODE_DIRECT:    pick_src = osc;
      MODE_PRESCALER: pick_src = pdv;
      MODE_PLL:       pick_src = vco;
      MODE_BASE:      pick_src = vco;
      default:        pick_src = osc;
    endcase
  endfunction : pick_src

  wire logic act_src  = pick_src(act_mode, osc_s2, pdiv_clk, vco_q);
  wire logic pend_src = pick_src(pend_mode, osc_s2, pdiv_clk, vco_q);

  // Direct drive skips the postdivider entirely
  wire logic [6:0] kdiv_eff = (act_mode == MODE_DIRECT) ? 7'h00 : {3'h0, act_kdiv};
  wire logic       restart  = (state == ST_SETTLE);

  // Postdivider, then the optional halving for the system clock
  clock_divider u_kdiv
  (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .restart_i   (restart),
    .src_i       (act_src),
    .factor_m1_i (kdiv_eff),
    .clk_o       (cpu_pre)
  );

  clock_divider u_sdiv
  (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .restart_i   (restart),
    .src_i       (cpu_pre),
    .factor_m1_i ({6'h00, act_half}),
    .clk_o       (sys_pre)
  );

  // Switch controller: never jump sources while a clock is high
  wire logic cfg_diff  = (pend_mode != act_mode) || (pend_half != act_half)
                      || (pend_pdiv != act_pdiv) || (pend_ndiv != act_ndiv)
                      || (pend_kdiv != act_kdiv);
  wire logic both_low  = ~cpu_clock_o & ~system_clock_o & ~pend_src;
  wire logic ref_ready = (pend_mode != MODE_PLL) || meas_valid;
  wire logic commit    = (state == ST_WAIT_LOW) && both_low && ref_ready;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:     next_state = cfg_diff ? ST_WAIT_LOW : ST_IDLE;
      ST_WAIT_LOW: next_state = commit ? ST_SETTLE : ST_WAIT_LOW;
      ST_SETTLE:   next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end

  // APB decode; zero wait states
  wire logic setup    = psel_i & ~penable_i;
  wire logic hit_ctrl = (paddr_i == `CKG_CTRL_OFS);
  wire logic hit_stat = (paddr_i == `CKG_STATUS_OFS);
  wire logic wr_ctrl  = psel_i & penable_i & pwrite_i & pready_o & hit_ctrl;
  wire logic strap_ld = (strap_cnt == `CKG_STRAP_WAIT);

  wire logic [31:0] ctrl_word = ({30'h0, pend_mode} << `CKG_MODE_LSB)
                              | ({31'h0, pend_half} << `CKG_HALF_BIT)
                              | ({28'h0, pend_pdiv} << `CKG_PDIV_LSB)
                              | ({25'h0, pend_ndiv} << `CKG_NDIV_LSB)
                              | ({28'h0, pend_kdiv} << `CKG_KDIV_LSB);
  wire logic [31:0] stat_word = ({30'h0, act_mode} << `CKG_ST_MODE_LSB)
                              | ({31'h0, act_half} << `CKG_ST_HALF_BIT)
                              | ({31'h0, (state != ST_IDLE)} << `CKG_ST_BUSY_BIT)
                              | ({31'h0, meas_valid} << `CKG_ST_LOCK_BIT);
  wire logic [31:0] rd_word   = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);

  // Bus answer, captured in the setup cycle
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= setup;
      pslverr_o <= setup & ~hit_ctrl & ~(hit_stat & ~pwrite_i); // Status is read-only
      prdata_o  <= (setup & ~pwrite_i) ? rd_word : 32'h0;
    end
  end

  // Pending configuration: strap once after reset, then software
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_cnt <= 2'h0;
      pend_mode <= clk_mode_t'(`CKG_MODE_RST);
      pend_half <= `CKG_HALF_RST;
      pend_pdiv <= `CKG_PDIV_RST;
      pend_ndiv <= `CKG_NDIV_RST;
      pend_kdiv <= `CKG_KDIV_RST;
    end
    else
    begin
      if (strap_cnt != 2'h3)
      begin
        strap_cnt <= strap_cnt + 2'h1;
      end
      if (wr_ctrl)
      begin
        pend_mode <= clk_mode_t'(pwdata_i[`CKG_MODE_LSB +: 2]);
        pend_half <= pwdata_i[`CKG_HALF_BIT];
        pend_pdiv <= pwdata_i[`CKG_PDIV_LSB +: 4];
        pend_ndiv <= pwdata_i[`CKG_NDIV_LSB +: 7];
        pend_kdiv <= pwdata_i[`CKG_KDIV_LSB +: 4];
      end
      else if (strap_ld)
      begin
        pend_mode <= clk_mode_t'(strap_s2);
      end
    end
  end

  // Active configuration moves only on a safe commit
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state    <= ST_IDLE;
      act_mode <= clk_mode_t'(`CKG_MODE_RST);
      act_half <= `CKG_HALF_RST;
      act_pdiv <= `CKG_PDIV_RST;
      act_ndiv <= `CKG_NDIV_RST;
      act_kdiv <= `CKG_KDIV_RST;
    end
    else
    begin
      state <= next_state;
      if (commit)
      begin
        act_mode <= pend_mode;
        act_half <= pend_half;
        act_pdiv <= pend_pdiv;
        act_ndiv <= pend_ndiv;
        act_kdiv <= pend_kdiv;
      end
    end
  end

  // Registered clock outputs; cpu and system clocks held low through the settle cycle
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cpu_clock_o                   <= 1'b0;
      system_clock_o                <= 1'b0;
      controlled_oscillator_clock_o <= 1'b0;
    end
    else
    begin
      cpu_clock_o                   <= cpu_pre & ~commit & ~restart;
      system_clock_o                <= sys_pre & ~commit & ~restart;
      controlled_oscillator_clock_o <= vco_q;
    end
  end

endmodule : clock_generation_unit

//--- bench/clock_generation_unit_sva.sv
`include "clkgen_consts.svh"

module clock_generation_unit_sva
(
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        oscillator_clock_i,
  input wire logic [1:0]  mode_strap_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        cpu_clock_o,
  input wire logic        system_clock_o,
  input wire logic        controlled_oscillator_clock_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Bus answers, one access cycle after setup
  setup_gets_ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  ready_single_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  ready_has_cause_a: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
    else $error("ready without setup");
  idle_data_zero_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside access");
  unmapped_error_a: assert property (psel_i && !penable_i && paddr_i[7:3] != 5'h0
    |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
  status_write_error_a: assert property (psel_i && !penable_i && pwrite_i
    && paddr_i == `CKG_STATUS_OFS |=> pslverr_o) else $error("status write not refused");
  ctrl_no_error_a: assert property (psel_i && !penable_i && paddr_i == `CKG_CTRL_OFS
    |=> !pslverr_o) else $error("control access refused");
  error_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");

  // Switching must never leave a one-cycle sliver on the cpu clock, nor a one-cycle high on the system clock
  cpu_high_width_a: assert property ($rose(cpu_clock_o) |=> cpu_clock_o)
    else $error("short cpu clock high");
  cpu_low_width_a: assert property ($fell(cpu_clock_o) |=> !cpu_clock_o)
    else $error("short cpu clock low");
  sys_high_width_a: assert property ($rose(system_clock_o) |=> system_clock_o)
    else $error("short system clock high");
endmodule : clock_generation_unit_sva

bind clock_generation_unit clock_generation_unit_sva u_sva
(
  .clk_i(clk_i), .resetn_i(resetn_i), .oscillator_clock_i(oscillator_clock_i),
  .mode_strap_i(mode_strap_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .cpu_clock_o(cpu_clock_o), .system_clock_o(system_clock_o),
  .controlled_oscillator_clock_o(controlled_oscillator_clock_o)
);

//--- bench/testbench.sv
`include "clkgen_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i, resetn_i, psel, penable, pwrite, err;
  logic        pready, pslverr, cpu_clk, sys_clk, vco_clk;
  logic [1:0]  strap;
  // Oscillator divider has one driver; its start value sits here
  logic        osc = 1'b0;
  logic [2:0]  osc_cnt = 3'h0;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          err_count, tests_run, n_cpu, n_sys, n_vco;
  // Mode words and edge counts expected in 960 cycles, osc period 8
  logic [31:0] cfg [5] = '{32'h0, 32'h4, 32'h00020011, 32'h00030106, 32'h00010007};
  int          e_cpu [5] = '{120, 120, 20, 60, 48};
  int          e_sys [5] = '{120, 60, 20, 30, 24};
  int          e_vco [5] = '{0, 0, 0, 240, 96};

  clock_generation_unit u_dut
  (
    .clk_i(clk_i), .resetn_i(resetn_i), .oscillator_clock_i(osc), .mode_strap_i(strap),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cpu_clock_o(cpu_clk), .system_clock_o(sys_clk), .controlled_oscillator_clock_o(vco_clk)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Oscillator at an eighth of the clock, inside the sampling limit
  always @(posedge clk_i)
  begin
    osc_cnt <= osc_cnt + 3'h1;
    osc <= osc_cnt[2];
  end

  task finish_test;
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  // Edge counts may slip by a sampling phase at each end
  task check_near(input int got, input int exp);
    tests_run++;
    if (got < exp - 2 || got > exp + 2)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : check_near

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check_word({31'h0, pready}, 32'h1);
  endtask : apb

  // Poll status until the switch engine is idle again; the two idle
  // edges let a write that lands in a settle cycle raise busy first
  task wait_idle;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 100; i++)
    begin
      apb(1'b0, `CKG_STATUS_OFS, 32'h0);
      if (rd[3] === 1'b0) break;
    end
    check_word({31'h0, rd[3]}, 32'h0);
  endtask : wait_idle

  task count_clocks;
    logic pc, ps, pv;
    {pc, ps, pv} = {cpu_clk, sys_clk, vco_clk};
    {n_cpu, n_sys, n_vco} = {32'h0, 32'h0, 32'h0};
    repeat (960)
    begin
      @(posedge clk_i);
      n_cpu += int'(cpu_clk && !pc);
      n_sys += int'(sys_clk && !ps);
      n_vco += int'(vco_clk && !pv);
      {pc, ps, pv} = {cpu_clk, sys_clk, vco_clk};
    end
  endtask : count_clocks

  initial
  begin
    {resetn_i, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 40'h0;
    {err_count, tests_run} = {32'h0, 32'h0};
    strap = 2'b11;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Strap lands a few edges after release
    repeat (5) @(posedge clk_i);
    apb(1'b0, `CKG_CTRL_OFS, 32'h0);
    check_word(rd, 32'h3);
    wait_idle;
    check_word(rd & 32'h7, 32'h3);
    apb(1'b1, `CKG_CTRL_OFS, 32'hFFFFFFFF);
    apb(1'b0, `CKG_CTRL_OFS, 32'h0);
    check_word(rd, 32'h000F7FF7);
    // Refused accesses give an error and no data
    apb(1'b0, 8'h08, 32'h0);
    check_word({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, `CKG_STATUS_OFS, 32'h2);
    check_word({31'h0, err}, 32'h1);
    apb(1'b1, 8'h0C, 32'h2);
    check_word({31'h0, err}, 32'h1);
    // A newer request replaces one still pending
    apb(1'b1, `CKG_CTRL_OFS, 32'h2);
    apb(1'b1, `CKG_CTRL_OFS, 32'h1);
    wait_idle;
    check_word(rd & 32'h7, 32'h1);
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, `CKG_CTRL_OFS, cfg[k]);
      wait_idle;
      check_word(rd & 32'h7, cfg[k] & 32'h7);
      repeat (50) @(posedge clk_i);
      count_clocks;
      check_near(n_cpu, e_cpu[k]);
      check_near(n_sys, e_sys[k]);
      if (e_vco[k] > 0) check_near(n_vco, e_vco[k]);
    end
    finish_test;
  end

  // Several times the expected run of some five thousand cycles
  initial
  begin
    #800000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    finish_test;
  end
endmodule : testbench
